// [dv/cantb_core_checker.sv]
// Concurrent checks on the ports of the CAN register core.
// Assumes one clock, pclk, and the active-low asynchronous reset presetn.
`timescale 1ns/1ps
`default_nettype none
module cantb_core_checker (
  input wire logic       pclk,
  input wire logic       presetn,
  input wire logic       psel,
  input wire logic       penable,
  input wire logic       pready,
  input wire logic       pslverr,
  input wire logic       tq_tick,
  input wire logic       sample_point,
  input wire logic       bit_start,
  input wire logic       tx_error,
  input wire logic       rx_error_minor,
  input wire logic       rx_error_major,
  input wire logic       arb_won,
  input wire logic [2:0] rx_stored,
  input wire logic [2:0] tx_done,
  input wire logic [2:0] rx_allowed,
  input wire logic [2:0] tx_request,
  input wire logic       tx_complete,
  input wire logic       error_passive,
  input wire logic       bus_off
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // The two phases of a register access.
  sequence setup_s;
    psel && !penable;
  endsequence
  sequence access_s;
    psel && penable;
  endsequence

  // Register access timing, error reply and engine-side flags.
  wait_state_a: assert property (
    setup_s ##1 access_s |-> !pready ##1 pready)
    else $error("access answered without one wait state");
  err_reply_a: assert property (pslverr |-> pready)
    else $error("error reply outside the answer cycle");
  rx_block_a: assert property (
    rx_stored[0] && rx_allowed[0] |=> !rx_allowed[0] && !tx_request[0])
    else $error("stored message did not block the buffer");
  held_store_a: assert property (
    rx_stored[0] && !rx_allowed[0] && !tx_request[0] && !psel
      |=> !tx_request[0])
    else $error("message stored into a held buffer");
  req_done_a: assert property (
    tx_done[0] && tx_request[0] |=> !tx_request[0])
    else $error("serviced request still pending");
  txc_cause_a: assert property (
    tx_complete |-> arb_won || (tx_done != 3'h0))
    else $error("transmit completion without cause");
  pass_cause_a: assert property ($rose(error_passive) |->
    $past(tx_error || rx_error_minor || rx_error_major))
    else $error("passive state entered without an error");
  boff_cause_a: assert property ($rose(bus_off) |-> $past(tx_error))
    else $error("bus-off entered without a transmit error");
  tick_order_a: assert property (
    (sample_point || bit_start) |-> tq_tick && !(sample_point && bit_start))
    else $error("bit event off a quantum boundary");
endmodule

// Every checker port meets the core port of the same name.
bind cantb_core cantb_core_checker u_chk (.*);
`default_nettype wire

// [dv/cantb_core_tb.sv]
// Self-checking bench for the CAN register core over APB.
// Assumes the engine model drives every event input of the core.
`timescale 1ns/1ps
`default_nettype none
module cantb_core_tb
  import cantb_pkg::*;
;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr, core_mem_rdata, core_mem_wdata;
  logic [31:0] pwdata, prdata, rd;
  logic        tq_tick, sample_point, bit_start, tx_complete, err;
  logic        error_passive, bus_off, core_idle, bus_edge, frame_seen;
  logic        frame_remote, tx_error, tx_success, arb_won, rx_success;
  logic        rx_error_minor, rx_error_major, rx_acc_code, core_mem_we;
  logic [10:0] frame_ident;
  logic [3:0]  frame_length;
  logic [2:0]  rx_stored, tx_done, buf_busy, rx_allowed, tx_request;
  logic [5:0]  core_mem_addr;
  int          n_mismatch, n_checks, n;

  // Free-running bus clock of 50 ns.
  initial
  begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  // Every port meets the bench signal of the same name.
  cantb_core dut (.*);

  cantb_engine_model eng (.*);

  task automatic give_verdict();
    if (n_mismatch == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("Error at %0t ns: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // One APB transfer; the request is held until pready is sampled high.
  task automatic apb(input logic wr, input logic [5:0] idx,
                     input logic [7:0] wd);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h00_0000, wd};
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 20 && pready !== 1'b1; i++)
      @(posedge pclk);
    if (i == 20)
    begin
      n_mismatch++;
      give_verdict();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [5:0] idx, input logic [7:0] d);
    apb(1'b1, idx, d);
  endtask

  task automatic rdc(input logic [5:0] idx, input logic [7:0] exp);
    apb(1'b0, idx, 8'h00);
    chk(rd, {24'h00_0000, exp});
  endtask

  function automatic logic [5:0] win(input logic [3:0] off);
    return {WIN_TOP, off};
  endfunction

  // Cycles until the next quantum tick (or bit start) is sampled.
  task automatic tick_gap(input bit sel);
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end while (!(sel ? bit_start : tq_tick) && n < 200);
  endtask

  task automatic do_reset();
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
  endtask

  // Main sequence of register scenarios.
  initial
  begin
    {n_mismatch, n_checks, n} = '0;
    {psel, penable, pwrite, paddr, pwdata, presetn} = '0;
    do_reset();
    rdc(IDX_PRESC, PRESC_RST);
    rdc(IDX_SEGMENT, 8'h23);
    rdc(IDX_PAGE, 8'h00);
    rdc(win(OFF_TEC), 8'h00);
    wr(IDX_PRESC, 8'h01);
    rdc(IDX_PRESC, 8'h01);
    wr(IDX_CTRL, 8'h01);
    wr(IDX_PRESC, 8'h3F);
    rdc(IDX_PRESC, 8'h01);
    wr(IDX_SEGMENT, 8'h00);
    rdc(IDX_SEGMENT, 8'h23);
    repeat (2) tick_gap(1'b0);
    chk(n, 2);
    repeat (2) tick_gap(1'b1);
    chk(n, 16);
    // An edge in segment one stretches the bit by one quantum (18 clocks);
    // the cycle of the pulse itself is not counted.
    eng.bus_edge <= 1'b1;
    @(posedge pclk) eng.bus_edge <= 1'b0;
    tick_gap(1'b1);
    chk(n, 17);
    eng.core_idle <= 1'b0;
    wr(IDX_CTRL, 8'h00);
    rdc(IDX_CTRL, 8'h01);
    eng.core_idle <= 1'b1;
    rdc(IDX_STATUS, 8'h04);
    rdc(IDX_CTRL, 8'h00);
    wr(IDX_PAGE, 8'h05);
    wr(win(OFF_ID_HIGH), 8'hFF);
    rdc(win(OFF_ID_HIGH), 8'h00);
    wr(IDX_PAGE, 8'h04);
    rdc(win(OFF_ID_HIGH), 8'h00);
    rdc(6'h06, 8'h00);
    chk({31'h0000_0000, err}, 1);
    wr(IDX_PAGE, 8'h00);
    eng.frame(11'h5A3, 1'b1, 4'h5);
    rdc(win(OFF_ID_HIGH), 8'hB4);
    rdc(win(OFF_ID_LOW), 8'h75);
    repeat (17) eng.ev(4, 3'h0);
    rdc(win(OFF_REC), 8'h88);
    rdc(IDX_STATUS, 8'h06);
    eng.ev(5, 3'h0);
    rdc(win(OFF_REC), 8'h78);
    repeat (2) eng.ev(3, 3'h0);
    eng.ev(5, 3'h0);
    rdc(win(OFF_REC), 8'h79);
    repeat (16) eng.ev(0, 3'h0);
    rdc(win(OFF_TEC), 8'h80);
    rdc(IDX_STATUS, 8'h06);
    eng.ev(1, 3'h0);
    rdc(win(OFF_TEC), 8'h7F);
    rdc(IDX_STATUS, 8'h04);
    repeat (17) eng.ev(0, 3'h0);
    rdc(win(OFF_TEC), 8'h07);
    chk({31'h0000_0000, bus_off}, 1);
    do_reset();
    rdc(win(OFF_TEC), 8'h00);
    wr(IDX_PAGE, 8'h01);
    wr(win(OFF_ID_HIGH), 8'hA5);
    wr(win(OFF_ID_LOW), 8'h58);
    rdc(win(OFF_ID_HIGH), 8'hA5);
    rdc(win(OFF_ID_LOW), 8'h58);
    chk({24'h00_0000, core_mem_rdata}, 8'hA5);
    eng.ev(6, 3'h1);
    rdc(win(OFF_BCSR), 8'h0C);
    rdc(IDX_RXFLAG, 8'h01);
    wr(win(OFF_BCSR), 8'h00);
    rdc(win(OFF_BCSR), 8'h00);
    rdc(IDX_RXFLAG, 8'h00);
    wr(win(OFF_BCSR), 8'h01);
    eng.ev(6, 3'h1);
    rdc(win(OFF_BCSR), 8'h01);
    wr(win(OFF_DATA_HI), 8'h3C);
    rdc(win(OFF_BCSR), 8'h05);
    chk({29'h0000_0000, tx_request}, 1);
    eng.ev(7, 3'h1);
    rdc(win(OFF_BCSR), 8'h01);
    wr(win(OFF_DATA_HI), 8'h3C);
    wr(win(OFF_BCSR), 8'h00);
    rdc(win(OFF_BCSR), 8'h00);
    wr(IDX_CTRL, 8'h02);
    wr(win(OFF_BCSR), 8'h01);
    wr(win(OFF_DATA_HI), 8'h3C);
    eng.ev(2, 3'h0);
    eng.ev(7, 3'h1);
    rdc(win(OFF_BCSR), 8'h00);
    eng.buf_busy <= 3'h1;
    wr(win(OFF_BCSR), 8'h01);
    rdc(win(OFF_BCSR), 8'h02);
    eng.buf_busy <= 3'h0;
    rdc(win(OFF_BCSR), 8'h00);
    give_verdict();
  end
endmodule
`default_nettype wire

// [dv/cantb_engine_model.sv]
// Behavioural protocol engine that drives the core's event inputs.
// Assumes callers invoke its tasks from one process, on pclk.
`timescale 1ns/1ps
`default_nettype none
module cantb_engine_model (
  input  wire logic pclk,
  output logic        core_idle,
  output logic        bus_edge,
  output logic        frame_seen,
  output logic [10:0] frame_ident,
  output logic        frame_remote,
  output logic [3:0]  frame_length,
  output logic        tx_error,
  output logic        tx_success,
  output logic        arb_won,
  output logic        rx_error_minor,
  output logic        rx_error_major,
  output logic        rx_success,
  output logic [2:0]  rx_stored,
  output logic        rx_acc_code,
  output logic [2:0]  tx_done,
  output logic [2:0]  buf_busy,
  output logic        core_mem_we,
  output logic [5:0]  core_mem_addr,
  output logic [7:0]  core_mem_wdata
);
  // Idle engine at start; the store port is left unused.
  initial
  begin
    {bus_edge, frame_seen, frame_remote, tx_error, tx_success} = '0;
    {arb_won, rx_error_minor, rx_error_major, rx_success} = '0;
    {rx_stored, rx_acc_code, tx_done, buf_busy, core_mem_we} = '0;
    {frame_ident, frame_length, core_mem_addr, core_mem_wdata} = '0;
    core_idle = 1'b1;
  end

  // One-cycle event pulse; kind 6 stores with filter one accepting.
  task automatic ev(input int k, input logic [2:0] b);
    @(posedge pclk);
    case (k)
      0: tx_error <= 1'b1;
      1: tx_success <= 1'b1;
      2: arb_won <= 1'b1;
      3: rx_error_minor <= 1'b1;
      4: rx_error_major <= 1'b1;
      5: rx_success <= 1'b1;
      6: {rx_stored, rx_acc_code} <= {b, 1'b1};
      default: tx_done <= b;
    endcase
    @(posedge pclk);
    {tx_error, tx_success, arb_won, rx_error_minor} <= '0;
    {rx_error_major, rx_success, rx_stored, rx_acc_code, tx_done} <= '0;
  endtask

  // Frame header pulse.
  // Header fields are valid only with the pulse; afterwards they flip.
  task automatic frame(input logic [10:0] id, input logic r,
                       input logic [3:0] l);
    @(posedge pclk);
    {frame_seen, frame_ident, frame_remote, frame_length} <= {1'b1, id, r, l};
    @(posedge pclk);
    {frame_seen, frame_ident, frame_remote, frame_length} <= {1'b0, ~id, ~r, ~l};
  endtask
endmodule
`default_nettype wire

// [rtl/cantb_core.sv]
// Register core of a CAN controller: bit timing, pages, counters, buffers.
// Assumes an APB master on pclk and a protocol engine on the same clock.
// Functional notes
// [RQ1] Timing registers writable only in standby.
// [RQ2] Resync adjustment capped at jump width plus one.
// [RQ3] Quantum equals prescaler plus one clocks.
// [RQ4] Bit time is segments plus three quanta.
// [RQ5] Segment fields plus one; reset value 23h.
// [RQ6] Page selector maps window contents.
// [RQ7] Capture last identifier, remote flag, length.
// [RQ8] Nine-bit transmit count, +8 / -1.
// [RQ9] Passive above 127, bus-off at 256.
// [RQ10] Receive count +1/+8, -1 or reload 120.
// [RQ11] Buffer holds eleven-bit identifier in two bytes.
// [RQ12] Remote flag one means remote frame.
// [RQ13] Length code 0 to 8, eight data bytes.
// [RQ14] Last data byte write raises transmit request.
// [RQ15] Acceptance code clears with pending or flag.
// [RQ16] Pending set on stored message or request.
// [RQ17] Clearing pending also clears receive flag.
// [RQ18] Hardware clears pending when request serviced.
// [RQ19] Busy shows protocol engine using buffer.
// [RQ20] Hold blocks reception; release cancels request.
// [RQ21] Early mode clears hold after transmission.
// [RQ22] Hold ignores writes while buffer busy.
// [RQ23] Early mode completes on won arbitration.
// [RQ24] Standby after transfer; run reads one meanwhile.
// [RQ25] Refused timing write leaves no trace.
// [RQ26] Reserved pages read zero, ignore writes.
`timescale 1ns/1ps
`default_nettype none
module cantb_core
  import cantb_pkg::*;
#(
  parameter int PADDR_W = 8
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         psel,
  input  wire logic         penable,
  input  wire logic         pwrite,
  input  wire logic [PADDR_W-1:0] paddr,
  input  wire logic [31:0]  pwdata,
  output logic [31:0]       prdata,
  output logic              pready,
  output logic              pslverr,
  input  wire logic         core_idle,
  input  wire logic         bus_edge,
  output logic              tq_tick,
  output logic              sample_point,
  output logic              bit_start,
  input  wire logic         frame_seen,
  input  wire logic [10:0]  frame_ident,
  input  wire logic         frame_remote,
  input  wire logic [3:0]   frame_length,
  input  wire logic         tx_error,
  input  wire logic         tx_success,
  input  wire logic         arb_won,
  input  wire logic         rx_error_minor,
  input  wire logic         rx_error_major,
  input  wire logic         rx_success,
  input  wire logic [2:0]   rx_stored,
  input  wire logic         rx_acc_code,
  input  wire logic [2:0]   tx_done,
  input  wire logic [2:0]   buf_busy,
  input  wire logic         core_mem_we,
  input  wire logic [5:0]   core_mem_addr,
  input  wire logic [7:0]   core_mem_wdata,
  output logic [7:0]        core_mem_rdata,
  output logic [2:0]        rx_allowed,
  output logic [2:0]        tx_request,
  output logic              tx_complete,
  output logic              error_passive,
  output logic              bus_off
);
  initial
  begin
    if (PADDR_W < 8) $error("cantb_core needs at least 8 address bits");
  end

  logic       run_req_r, run_state_r, etx_r, phase_r;
  logic [7:0] presc_r, segment_r, last_high_r, last_low_r;
  logic [2:0] page_r;
  logic [8:0] tec_r;
  logic [7:0] rec_r;
  logic [2:0] rdy_r, lock_r, acc_r, rxf_r;
  logic [31:0] prdata_r;
  logic       rd_go, wr_go, mapped;
  logic [5:0] idx;
  logic [3:0] woff;
  logic [7:0] wdat, rd_val;
  logic [1:0] cur_buf;
  logic       cur_is_buf;

  cantb_mem_if #(.AW(6)) mem ();

  cantb_msg_store #(.AW(6)) u_store (
    .pclk    (pclk),
    .presetn (presetn),
    .mem     (mem.store)
  );

  // Maps a page code to a buffer slot; bit 2 says a buffer page.
  function automatic logic [2:0] page_buf(input logic [2:0] pg);
    logic [2:0] r;
    r = 3'h0;
    if (pg >= PAGE_BUF_LO && pg <= PAGE_BUF_HI)
      r = {1'b1, 2'(pg - PAGE_BUF_LO)};
    return r;
  endfunction

  // Bus decode; a transfer ends in the second access cycle.
  assign idx     = paddr[7:2];
  assign woff    = idx[3:0];
  assign wdat    = pwdata[7:0];
  assign pready  = psel & penable & phase_r;
  assign rd_go   = psel & penable & ~phase_r & ~pwrite;
  assign wr_go   = pready & pwrite;
  assign mapped  = (idx <= IDX_RXFLAG) || (idx[5:4] == WIN_TOP);
  assign pslverr = pready & ~mapped;
  assign prdata  = prdata_r;
  assign {cur_is_buf, cur_buf} = page_buf(page_r);

  // Access phase tracker.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn) phase_r <= 1'b0;
    else phase_r <= psel & penable & ~phase_r;
  end

  // Store ports: CPU addresses follow the window, core port passes through.
  assign mem.cpu_addr   = {cur_buf, woff};
  assign mem.cpu_wdata  = wdat;
  // [RQ11] Identifier bytes.
  // [RQ13] Data bytes and length.
  assign mem.cpu_we     = wr_go && idx[5:4] == WIN_TOP && cur_is_buf
                          && woff <= OFF_DATA_HI;
  assign mem.core_we    = core_mem_we;
  assign mem.core_addr  = core_mem_addr;
  assign mem.core_wdata = core_mem_wdata;
  assign core_mem_rdata = mem.core_rdata;

  // Control register and standby handshake.
  // [RQ24] Run drops after transfer.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      run_req_r   <= 1'b0;
      run_state_r <= 1'b0;
      etx_r       <= 1'b0;
    end
    else
    begin
      if (wr_go && idx == IDX_CTRL)
      begin
        run_req_r <= wdat[CTRL_RUN];
        etx_r     <= wdat[CTRL_ETX];
      end
      if (run_req_r) run_state_r <= 1'b1;
      else if (core_idle) run_state_r <= 1'b0;
    end
  end

  // Timing and page registers.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      presc_r   <= PRESC_RST;
      segment_r <= SEGMENT_RST;
      page_r    <= 3'h0;
    end
    else if (wr_go)
    begin
      // [RQ1] Standby write gate.
      // [RQ25] Refused writes dropped.
      if (idx == IDX_PRESC && !run_state_r) presc_r <= wdat;
      if (idx == IDX_SEGMENT && !run_state_r) segment_r <= {1'b0, wdat[6:0]};
      if (idx == IDX_PAGE) page_r <= wdat[2:0];
    end
  end

  // Quantum prescaler.
  logic [5:0] presc_cnt_r;
  // [RQ3] Quantum length.
  assign tq_tick = run_state_r && presc_cnt_r == presc_r[5:0];
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn) presc_cnt_r <= 6'h00;
    else if (!run_state_r || tq_tick) presc_cnt_r <= 6'h00;
    else presc_cnt_r <= presc_cnt_r + 6'h01;
  end

  // Bit segment sequencer with resynchronization.
  cantb_bit_t st_r;
  logic [4:0] qcnt_r, ext_r, len1, len2, sjw, err1, cut2, rem2;
  logic       edge_r;
  assign sjw  = 5'(presc_r[7:6]) + 5'h01;
  assign len1 = 5'(segment_r[3:0]) + 5'h01;
  assign len2 = 5'(segment_r[6:4]) + 5'h01;
  // [RQ2] Adjustment capped.
  assign err1 = (qcnt_r + 5'h01 < sjw) ? qcnt_r + 5'h01 : sjw;
  assign rem2 = len2 - qcnt_r;
  assign cut2 = (rem2 < sjw) ? rem2 : sjw;
  // [RQ4] Sync plus two segments.
  assign bit_start    = tq_tick && st_r == ST_SYNC;
  assign sample_point = tq_tick && st_r == ST_SEG1
                        && qcnt_r + 5'h01 >= len1 + ext_r;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_r   <= ST_SYNC;
      qcnt_r <= 5'h00;
      ext_r  <= 5'h00;
      edge_r <= 1'b0;
    end
    else if (!run_state_r)
    begin
      st_r   <= ST_SYNC;
      qcnt_r <= 5'h00;
      ext_r  <= 5'h00;
      edge_r <= 1'b0;
    end
    else
    begin
      if (bus_edge) edge_r <= 1'b1;
      if (tq_tick)
      begin
        edge_r <= 1'b0;
        unique case (st_r)
          ST_SYNC:
          begin
            st_r   <= ST_SEG1;
            qcnt_r <= 5'h00;
            ext_r  <= 5'h00;
          end
          ST_SEG1:
          begin
            // [RQ5] Segment one length.
            if (sample_point)
            begin
              st_r   <= ST_SEG2;
              qcnt_r <= 5'h00;
            end
            else
            begin
              qcnt_r <= qcnt_r + 5'h01;
              if ((edge_r || bus_edge) && ext_r == 5'h00) ext_r <= err1;
            end
          end
          ST_SEG2:
          begin
            // [RQ5] Segment two, shortened on edge.
            if ((edge_r || bus_edge) && cut2 == rem2)
            begin
              st_r   <= ST_SEG1;
              qcnt_r <= 5'h00;
              ext_r  <= 5'h00;
            end
            else if (qcnt_r + 5'h01 + ((edge_r || bus_edge) ? cut2 : 5'h00)
                     >= len2)
              st_r <= ST_SYNC;
            else qcnt_r <= qcnt_r + 5'h01;
          end
        endcase
      end
    end
  end

  // Last frame capture; the bus event wins over a CPU write.
  // [RQ7] Diagnosis capture.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      last_high_r <= 8'h00;
      last_low_r  <= 8'h00;
    end
    else if (frame_seen)
    begin
      last_high_r <= frame_ident[10:3];
      last_low_r  <= {frame_ident[2:0], frame_remote, frame_length};
    end
    else if (wr_go && idx[5:4] == WIN_TOP && page_r == PAGE_DIAG)
    begin
      if (woff == OFF_ID_HIGH) last_high_r <= wdat;
      if (woff == OFF_ID_LOW) last_low_r <= wdat;
    end
  end

  // Fault confinement counters.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tec_r <= 9'h000;
      rec_r <= 8'h00;
    end
    else
    begin
      // [RQ8] Transmit count steps.
      if (tx_error)
        tec_r <= (tec_r > TEC_MAX - TEC_STEP) ? TEC_MAX : tec_r + TEC_STEP;
      else if (tx_success && tec_r != 9'h000)
        tec_r <= tec_r - 9'h001;
      // [RQ10] Receive count steps.
      if (rx_error_major)
        rec_r <= (rec_r > 8'hFF - REC_STEP) ? 8'hFF : rec_r + REC_STEP;
      else if (rx_error_minor)
        rec_r <= (rec_r == 8'hFF) ? 8'hFF : rec_r + 8'h01;
      else if (rx_success)
      begin
        if (rec_r > REC_HIGH) rec_r <= REC_RELOAD;
        else if (rec_r != 8'h00) rec_r <= rec_r - 8'h01;
      end
    end
  end
  // [RQ9] Confinement states.
  assign bus_off       = tec_r >= BUSOFF_AT;
  assign error_passive = ~bus_off
                         & (tec_r > PASS_LIMIT || 9'(rec_r) > PASS_LIMIT);
  // [RQ23] Early completion.
  assign tx_complete   = etx_r ? arb_won : |tx_done;

  // Per-buffer ready, hold, acceptance and receive flag.
  genvar b;
  generate
    for (b = 0; b < 3; b++)
    begin : g_buf
      logic here, bc_wr, rdy_clr, rxf_clr, lock_wr, last_wr;
      assign here    = wr_go && idx[5:4] == WIN_TOP && cur_is_buf
                       && cur_buf == 2'(b);
      assign bc_wr   = here && woff == OFF_BCSR;
      assign last_wr = here && woff == OFF_DATA_HI;
      assign rdy_clr = bc_wr && !wdat[BC_RDY] && !lock_r[b];
      assign rxf_clr = wr_go && idx == IDX_RXFLAG && !wdat[b];
      // [RQ22] Hold frozen while busy.
      assign lock_wr = bc_wr && !buf_busy[b];
      // [RQ20] Reception only when not held.
      assign rx_allowed[b] = ~lock_r[b] & ~rdy_r[b];
      assign tx_request[b] = lock_r[b] & rdy_r[b];
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          rdy_r[b]  <= 1'b0;
          lock_r[b] <= 1'b0;
          acc_r[b]  <= 1'b0;
          rxf_r[b]  <= 1'b0;
        end
        else
        begin
          // [RQ17] Clearing pending clears flag too.
          if (rdy_clr) rdy_r[b] <= 1'b0;
          if (rdy_clr || rxf_clr) rxf_r[b] <= 1'b0;
          // [RQ15] Acceptance code clears.
          if (rdy_clr || rxf_clr) acc_r[b] <= 1'b0;
          if (lock_wr) lock_r[b] <= wdat[BC_LOCK];
          // [RQ20] Release cancels request.
          if (lock_wr && !wdat[BC_LOCK] && lock_r[b]) rdy_r[b] <= 1'b0;
          // [RQ18] Request serviced.
          if (tx_done[b] && lock_r[b]) rdy_r[b] <= 1'b0;
          // [RQ21] Early mode releases hold.
          if (tx_done[b] && etx_r && !buf_busy[b]) lock_r[b] <= 1'b0;
          // [RQ16] Pending set on stored message.
          // [RQ15] Acceptance code captured.
          if (rx_stored[b] && !lock_r[b])
          begin
            rdy_r[b] <= 1'b1;
            rxf_r[b] <= 1'b1;
            acc_r[b] <= rx_acc_code;
          end
          // [RQ14] Last data byte requests.
          // [RQ16] Pending set on request.
          if (last_wr && lock_r[b] && !(lock_wr && !wdat[BC_LOCK]))
            rdy_r[b] <= 1'b1;
        end
      end
    end
  endgenerate

  // Read value mux.
  always_comb
  begin
    rd_val = 8'h00;
    if (idx[5:4] == WIN_TOP)
    begin
      // [RQ6] Page mapping.
      // [RQ26] Reserved pages read zero.
      if (page_r == PAGE_DIAG)
      begin
        if (woff == OFF_ID_HIGH) rd_val = last_high_r;
        else if (woff == OFF_ID_LOW) rd_val = last_low_r;
        else if (woff == OFF_TEC) rd_val = tec_r[7:0];
        else if (woff == OFF_REC) rd_val = rec_r;
      end
      else if (cur_is_buf)
      begin
        // [RQ12] Remote flag stored as written.
        if (woff <= OFF_DATA_HI) rd_val = mem.cpu_rdata;
        // [RQ19] Busy from engine.
        else if (woff == OFF_BCSR)
          rd_val = {4'h0, acc_r[cur_buf], rdy_r[cur_buf],
                    buf_busy[cur_buf], lock_r[cur_buf]};
      end
    end
    else
    begin
      unique case (idx)
        IDX_CTRL:    rd_val = {6'h00, etx_r, run_req_r | run_state_r};
        IDX_PRESC:   rd_val = presc_r;
        IDX_SEGMENT: rd_val = segment_r;
        IDX_PAGE:    rd_val = {5'h00, page_r};
        IDX_STATUS:  rd_val = {5'h00, ~run_state_r, error_passive, bus_off};
        IDX_RXFLAG:  rd_val = {5'h00, rxf_r};
        default:     rd_val = 8'h00;
      endcase
    end
  end

  // Read data register, loaded in the first access cycle.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn) prdata_r <= 32'h0000_0000;
    else if (rd_go) prdata_r <= {24'h00_0000, rd_val};
  end
endmodule
`default_nettype wire

// [rtl/cantb_mem_if.sv]
// Two-port link between the core top and its message store.
// Assumes both ports run on the same clock as the store.
`timescale 1ns/1ps
`default_nettype none
interface cantb_mem_if #(parameter int AW = 6);
  logic          cpu_we;
  logic [AW-1:0] cpu_addr;
  logic [7:0]    cpu_wdata;
  logic [7:0]    cpu_rdata;
  logic          core_we;
  logic [AW-1:0] core_addr;
  logic [7:0]    core_wdata;
  logic [7:0]    core_rdata;
  modport store (input cpu_we, cpu_addr, cpu_wdata, core_we, core_addr,
                 core_wdata, output cpu_rdata, core_rdata);
  modport user  (output cpu_we, cpu_addr, cpu_wdata, core_we, core_addr,
                 core_wdata, input cpu_rdata, core_rdata);
endinterface
`default_nettype wire

// [rtl/cantb_msg_store.sv]
// Message store: identifier, length and data bytes of every buffer.
// Assumes one clock; read data of both ports come out of registers.
`timescale 1ns/1ps
`default_nettype none
module cantb_msg_store #(
  parameter int AW = 6
) (
  input  wire logic   pclk,
  input  wire logic   presetn,
  cantb_mem_if.store  mem
);
  logic [7:0] cells [2**AW];

  initial
  begin
    if (AW < 6) $error("cantb_msg_store needs at least 6 address bits");
  end

  // Writes; the core port wins when both hit the same cell.
  always_ff @(posedge pclk)
  begin
    if (mem.cpu_we) cells[mem.cpu_addr] <= mem.cpu_wdata;
    if (mem.core_we) cells[mem.core_addr] <= mem.core_wdata;
  end

  // Registered reads for both ports.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mem.cpu_rdata  <= 8'h00;
      mem.core_rdata <= 8'h00;
    end
    else
    begin
      mem.cpu_rdata  <= cells[mem.cpu_addr];
      mem.core_rdata <= cells[mem.core_addr];
    end
  end
endmodule
`default_nettype wire

// [rtl/cantb_pkg.sv]
// Shared constants for the CAN timing, buffer and counter core.
// Assumes an APB slave with 32-bit data and 8-bit registers in the low bits.
package cantb_pkg;
  // Register indexes; the byte address is four times the index.
  localparam logic [5:0] IDX_CTRL    = 6'h00;
  localparam logic [5:0] IDX_PRESC   = 6'h01;
  localparam logic [5:0] IDX_SEGMENT = 6'h02;
  localparam logic [5:0] IDX_PAGE    = 6'h03;
  localparam logic [5:0] IDX_STATUS  = 6'h04;
  localparam logic [5:0] IDX_RXFLAG  = 6'h05;
  localparam logic [1:0] WIN_TOP     = 2'h1;
  // Offsets inside the paged window.
  localparam logic [3:0] OFF_ID_HIGH = 4'h0;
  localparam logic [3:0] OFF_ID_LOW  = 4'h1;
  localparam logic [3:0] OFF_DATA_LO = 4'h2;
  localparam logic [3:0] OFF_DATA_HI = 4'h9;
  localparam logic [3:0] OFF_TEC     = 4'hE;
  localparam logic [3:0] OFF_REC     = 4'hF;
  localparam logic [3:0] OFF_BCSR    = 4'hF;
  // Page codes.
  localparam logic [2:0] PAGE_DIAG   = 3'h0;
  localparam logic [2:0] PAGE_BUF_LO = 3'h1;
  localparam logic [2:0] PAGE_BUF_HI = 3'h3;
  localparam logic [2:0] PAGE_FILT   = 3'h4;
  // Field positions.
  localparam int CTRL_RUN = 0;
  localparam int CTRL_ETX = 1;
  localparam int BC_ACC   = 3;
  localparam int BC_RDY   = 2;
  localparam int BC_BUSY  = 1;
  localparam int BC_LOCK  = 0;
  // Values after reset.
  localparam logic [7:0] PRESC_RST   = 8'h00;
  localparam logic [7:0] SEGMENT_RST = 8'h23;
  // Fault confinement figures.
  localparam logic [8:0] TEC_STEP    = 9'h008;
  localparam logic [8:0] TEC_MAX     = 9'h1FF;
  localparam logic [8:0] PASS_LIMIT  = 9'h07F;
  localparam logic [8:0] BUSOFF_AT   = 9'h100;
  localparam logic [7:0] REC_RELOAD  = 8'h78;
  localparam logic [7:0] REC_HIGH    = 8'h80;
  localparam logic [7:0] REC_STEP    = 8'h08;
  // Fixed part of a bit time in quanta (sync plus the two +1 terms).
  localparam logic [4:0] BIT_FIXED   = 5'h03;
  typedef enum logic [1:0] {ST_SYNC, ST_SEG1, ST_SEG2} cantb_bit_t;
endpackage
